//--- swp_sector_guard.sv
/*
  Sector write protection logic: register write guarding, per-sector
  persistent and dynamic locks, block range OR, lock bit in persistent
  or password mode, guard configuration programming.
  Assumes commands arrive as one-cycle strobes from logic on core_clk;
  write-guard pin is external and synchronised here by two flops; block-protect hit arrives already synchronous.
*/
`timescale 1ns/10ps
module swp_sector_guard (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  // Pins and neighbouring state
  input  wire logic                          writeGuardN,
  input  wire logic                          blockGuardHit,
  // Command strobe from host controller
  input  wire logic                          cmdValid,
  input  wire swp_pkg::swp_cmd_e             cmdCode,
  input  wire logic [swp_pkg::SECT_BITS-1:0] cmdSector,
  input  wire logic [63:0]                   cmdData,
  // Status
  output logic                               operationBusy,
  output logic                               programFault,
  output logic                               persistentBitLock,
  output logic [1:0]                         guardMode,
  output logic [7:0]                         statusOne,
  output logic [7:0]                         configOne,
  output logic                               lockReadValid,
  output logic                               lockReadData,
  output logic                               arrayGo
);

  typedef enum {
    SWP_IDLE,
    SWP_WAIT,
    SWP_READ,
    SWP_HOLD
  } swp_state_e;

  typedef struct packed {
    swp_state_e                   state;
    logic [swp_pkg::CNT_W-1:0]    cnt;
    logic [swp_pkg::CNT_W-1:0]    gap;
    logic                         busy;
    logic                         fault;
    logic [1:0]                   pbl;
    logic [3:0]                   mode;
    logic [63:0]                  pass;
    logic [7:0]                   stat;
    logic [7:0]                   cfg1;
    logic [7:0]                   learn;
    logic [swp_pkg::NUM_SECT-1:0] dyn;
    logic                         progPsl;
    logic                         erasePsl;
    logic                         setPbl;
    logic [1:0]                   newMode;
    logic                         rdValid;
    logic                         rdData;
    logic                         go;
  } swp_st_s;

  swp_st_s st;
  swp_st_s next_st;

  logic wgMeta;
  logic wgSync;
  logic memRd;
  logic [swp_pkg::NUM_SECT-1:0] pslBits;

  logic die;
  logic [1:0] dieMode;
  logic modeChosen;
  logic passwordMode;
  logic sectLocked;
  logic regGuarded;

  swp_lock_mem u_lock_mem (
    .core_clk (core_clk),
    .resetn   (resetn),
    .addr     (cmdSector),
    .progEn   (st.progPsl),
    .eraseEn  (st.erasePsl),
    .rdData   (memRd),
    .allBits  (pslBits)
  );

  // Pin crosses two flops before use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wgMeta <= 1'b1;
      wgSync <= 1'b1;
    end else begin
      wgMeta <= writeGuardN;
      wgSync <= wgMeta;
    end
  end

  always_comb begin
    die          = cmdSector[swp_pkg::DIE_BIT];
    dieMode      = die ? st.mode[3:2] : st.mode[1:0];
    modeChosen   = (dieMode != swp_pkg::MODE_DEFAULT);
    passwordMode = (dieMode == swp_pkg::MODE_PASSWORD);
    sectLocked   = blockGuardHit | !pslBits[cmdSector]
                 | !st.dyn[cmdSector];
    regGuarded   = !wgSync & st.stat[swp_pkg::STAT_WD_BIT];
  end

  always_comb begin
    next_st          = st;
    next_st.progPsl  = 1'b0;
    next_st.erasePsl = 1'b0;
    next_st.rdValid  = 1'b0;
    next_st.go       = 1'b0;
    if (st.gap != '0) begin
      next_st.gap = st.gap - 1'b1;
    end
    case (st.state)
      SWP_IDLE: begin
        if (cmdValid) begin
          next_st.fault = 1'b0;
          case (cmdCode)
            swp_pkg::SWP_WRITE_STAT: begin
              if (!regGuarded) begin
                next_st.stat = cmdData[7:0];
              end
            end
            swp_pkg::SWP_WRITE_CFG1: begin
              if (!regGuarded) begin
                // Bits 5:2 are one-time fields once a mode is chosen
                next_st.cfg1 = modeChosen ?
                  {cmdData[7:6], st.cfg1[5:2], cmdData[1:0]} :
                  cmdData[7:0];
                if (modeChosen && cmdData[5:2] != st.cfg1[5:2]) begin
                  next_st.fault = 1'b1;
                end
              end
            end
            swp_pkg::SWP_WRITE_CFGX: begin
              next_st.fault = modeChosen;
            end
            swp_pkg::SWP_WRITE_LEARN: begin
              if (modeChosen) begin
                next_st.fault = 1'b1;
              end else begin
                next_st.learn = cmdData[7:0];
              end
            end
            swp_pkg::SWP_PROG_PASS: begin
              if (modeChosen) begin
                next_st.fault = 1'b1;
              end else begin
                // Passcode cells only program toward zero
                next_st.pass = st.pass & cmdData;
                next_st.busy = 1'b1;
                next_st.cnt  = swp_pkg::CNT_W'(swp_pkg::PAGE_PROG_CYC);
                next_st.state = SWP_WAIT;
              end
            end
            swp_pkg::SWP_PROG_GUARD: begin
              if (modeChosen ||
                  cmdData[1:0] == swp_pkg::MODE_ILLEGAL) begin
                next_st.fault = 1'b1;
              end else begin
                next_st.newMode = cmdData[1:0];
                next_st.busy    = 1'b1;
                next_st.cnt = swp_pkg::CNT_W'(swp_pkg::PAGE_PROG_CYC);
                next_st.state = SWP_WAIT;
              end
            end
            swp_pkg::SWP_PROG_PSL, swp_pkg::SWP_ERASE_PSL: begin
              if (!st.pbl[die]) begin
                next_st.fault = 1'b1;
              end else if (cmdCode == swp_pkg::SWP_PROG_PSL) begin
                next_st.progPsl = 1'b1;
                next_st.busy    = 1'b1;
                next_st.cnt = swp_pkg::CNT_W'(swp_pkg::PAGE_PROG_CYC);
                next_st.state = SWP_WAIT;
              end else begin
                next_st.erasePsl = 1'b1;
                next_st.busy     = 1'b1;
                next_st.cnt = swp_pkg::CNT_W'(swp_pkg::SECT_ERASE_CYC);
                next_st.state = SWP_WAIT;
              end
            end
            swp_pkg::SWP_READ_PSL: begin
              next_st.cnt = swp_pkg::CNT_W'(swp_pkg::ARRAY_READ_CYC);
              next_st.state = SWP_READ;
            end
            swp_pkg::SWP_WRITE_DSL: begin
              next_st.dyn[cmdSector] = cmdData[0];
            end
            swp_pkg::SWP_CLEAR_PBL: begin
              next_st.pbl[die] = 1'b0;
            end
            swp_pkg::SWP_UNLOCK: begin
              if (!passwordMode || st.gap != '0) begin
                // Too early or wrong mode: refused, lock untouched
                next_st.fault = 1'b1;
              end else begin
                next_st.busy = 1'b1;
                next_st.cnt  = swp_pkg::CNT_W'(1);
                if (cmdData == st.pass) begin
                  next_st.setPbl = 1'b1;
                  next_st.state  = SWP_WAIT;
                end else begin
                  next_st.fault = 1'b1;
                  next_st.gap = swp_pkg::CNT_W'(swp_pkg::UNLOCK_GAP_CYC);
                  next_st.state = SWP_HOLD;
                end
              end
            end
            swp_pkg::SWP_ARRAY_OP: begin
              if (sectLocked) begin
                next_st.fault = 1'b1;
              end else begin
                next_st.go = 1'b1;
              end
            end
            default: begin
              next_st.fault = st.fault;
            end
          endcase
        end
      end
      SWP_WAIT: begin
        if (st.cnt > swp_pkg::CNT_W'(1)) begin
          next_st.cnt = st.cnt - 1'b1;
        end else begin
          if (st.setPbl) begin
            next_st.pbl[die] = 1'b1;
          end
          if (st.newMode != '0) begin
            // Each die programs its own mode field
            if (die) begin
              next_st.mode[3:2] = st.newMode;
            end else begin
              next_st.mode[1:0] = st.newMode;
            end
          end
          next_st.setPbl  = 1'b0;
          next_st.newMode = '0;
          next_st.busy    = 1'b0;
          next_st.state   = SWP_IDLE;
        end
      end
      SWP_READ: begin
        if (st.cnt > swp_pkg::CNT_W'(1)) begin
          next_st.cnt = st.cnt - 1'b1;
        end else begin
          next_st.rdValid = 1'b1;
          next_st.rdData  = memRd;
          next_st.state   = SWP_IDLE;
        end
      end
      SWP_HOLD: begin
        // Busy stays up through the whole retry gap after a mismatch
        if (st.gap <= swp_pkg::CNT_W'(1)) begin
          next_st.busy  = 1'b0;
          next_st.state = SWP_IDLE;
        end
      end
      default: begin
        next_st.state = SWP_IDLE;
      end
    endcase
  end

  // Reset sets the lock bit to 1 on both dies, whatever each die's mode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st       <= '0;
      st.state <= SWP_IDLE;
      st.pbl   <= 2'h3;
      st.mode  <= {swp_pkg::MODE_RESET, swp_pkg::MODE_RESET};
      st.pass  <= swp_pkg::PASS_RESET;
      st.stat  <= swp_pkg::STAT_RESET;
      st.cfg1  <= swp_pkg::CFG_RESET;
      st.dyn   <= '1;
    end else begin
      st <= next_st;
    end
  end

  // Password-mode dies come up locked: cleared on the first clocked cycle
  logic pwInit;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pwInit <= 1'b0;
    end else begin
      pwInit <= 1'b1;
    end
  end

  logic [1:0] pblOut;
  always_comb begin
    pblOut[0] = st.pbl[0] & (pwInit | st.mode[1:0] != swp_pkg::MODE_PASSWORD);
    pblOut[1] = st.pbl[1] & (pwInit | st.mode[3:2] != swp_pkg::MODE_PASSWORD);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      operationBusy     <= 1'b0;
      programFault      <= 1'b0;
      persistentBitLock <= 1'b1;
      guardMode         <= swp_pkg::MODE_RESET;
      statusOne         <= swp_pkg::STAT_RESET;
      configOne         <= swp_pkg::CFG_RESET;
      lockReadValid     <= 1'b0;
      lockReadData      <= 1'b1;
      arrayGo           <= 1'b0;
    end else begin
      operationBusy     <= st.busy;
      programFault      <= st.fault;
      persistentBitLock <= pblOut[die];
      guardMode         <= dieMode;
      statusOne         <= st.stat;
      configOne         <= st.cfg1;
      lockReadValid     <= st.rdValid;
      lockReadData      <= st.rdData;
      arrayGo           <= st.go;
    end
  end

endmodule

//--- swp_pkg.sv
/*
  Package for the sector write protection block: command codes, mode
  encodings, sizes and operation timing.
  Assumes a 20 MHz core clock; the program, erase and unlock gap counts are derived from it.
*/
package swp_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // Array shape: two dies, each with its own sector range
  localparam int unsigned SECT_BITS = 6;
  localparam int unsigned NUM_SECT  = 64;
  localparam int unsigned DIE_BIT   = 5;

  // Operation times
  localparam int unsigned PAGE_PROG_US   = 300;
  localparam int unsigned SECT_ERASE_US  = 1000;
  localparam int unsigned UNLOCK_GAP_US  = 100;
  localparam int unsigned ARRAY_READ_CYC = 2;
  localparam int unsigned PAGE_PROG_CYC  =
    (PAGE_PROG_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SECT_ERASE_CYC =
    (SECT_ERASE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned UNLOCK_GAP_CYC =
    (UNLOCK_GAP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 16;

  // Guard configuration mode field
  localparam logic [1:0] MODE_DEFAULT  = 2'h3;
  localparam logic [1:0] MODE_PERSIST  = 2'h2;
  localparam logic [1:0] MODE_PASSWORD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL  = 2'h0;
  localparam logic [1:0] MODE_RESET    = MODE_DEFAULT;

  // Reset values
  localparam logic [63:0] PASS_RESET  = 64'hffff_ffff_ffff_ffff;
  localparam logic [7:0]  STAT_RESET  = 8'h00;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam int unsigned STAT_WD_BIT = 7;

  // Commands from the host controller
  typedef enum logic [3:0] {
    SWP_NONE,
    SWP_WRITE_STAT,
    SWP_WRITE_CFG1,
    SWP_WRITE_CFGX,
    SWP_WRITE_LEARN,
    SWP_PROG_PASS,
    SWP_PROG_GUARD,
    SWP_PROG_PSL,
    SWP_ERASE_PSL,
    SWP_READ_PSL,
    SWP_WRITE_DSL,
    SWP_CLEAR_PBL,
    SWP_UNLOCK,
    SWP_ARRAY_OP
  } swp_cmd_e;

endpackage

//--- swp_lock_mem.sv
/*
  Nonvolatile persistent sector lock store: one bit per sector, single
  bit program to 0, bulk erase to 1, registered read.
  Assumes the caller sequences program/erase timing.
*/
`timescale 1ns/10ps
module swp_lock_mem (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  // Access
  input  wire logic [swp_pkg::SECT_BITS-1:0] addr,
  input  wire logic                          progEn,
  input  wire logic                          eraseEn,
  output logic                               rdData,
  output logic [swp_pkg::NUM_SECT-1:0]       allBits
);

  typedef struct packed {
    logic [swp_pkg::NUM_SECT-1:0] bits;
    logic                         rd;
  } swp_mem_s;

  swp_mem_s st;
  swp_mem_s next_st;

  always_comb begin
    next_st = st;
    if (eraseEn) begin
      next_st.bits = '1;
    end else if (progEn) begin
      next_st.bits[addr] = 1'b0;
    end
    next_st.rd = st.bits[addr];
  end

  // Unconfigured parts start with every sector unlocked
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{bits: '1, rd: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign rdData  = st.rd;
  assign allBits = st.bits;

endmodule

//--- swp_sector_guard_checker.sv
/*
  Checker for swp_sector_guard: concurrent assertions on its ports.
  Assumes one command at a time, issued only while busy is low.
*/
`timescale 1ns/10ps
module swp_sector_guard_checker (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              resetn,
  // Inputs of the block
  input wire logic              writeGuardN,
  input wire logic              blockGuardHit,
  input wire logic              cmdValid,
  input wire swp_pkg::swp_cmd_e cmdCode,
  input wire logic [5:0]        cmdSector,
  input wire logic [63:0]       cmdData,
  // Outputs of the block
  input wire logic              operationBusy,
  input wire logic              programFault,
  input wire logic              persistentBitLock,
  input wire logic [1:0]        guardMode,
  input wire logic [7:0]        statusOne,
  input wire logic [7:0]        configOne,
  input wire logic              lockReadValid,
  input wire logic              lockReadData,
  input wire logic              arrayGo
);
  localparam int RdLat = 2 + swp_pkg::ARRAY_READ_CYC;
  logic              take;
  logic [15:0]       busyLen;
  swp_pkg::swp_cmd_e lastCmd;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  assign take = cmdValid && !operationBusy;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busyLen <= 16'h0;
      lastCmd <= swp_pkg::SWP_NONE;
    end else begin
      busyLen <= operationBusy ? busyLen + 16'h1 : 16'h0;
      if (take) begin
        lastCmd <= cmdCode;
      end
    end
  end
  wp_guard_a: assert property (
    !writeGuardN [*3] ##0 (take && statusOne[7] && cmdCode inside
    {swp_pkg::SWP_WRITE_STAT, swp_pkg::SWP_WRITE_CFG1})
    |=> ($stable(statusOne) && $stable(configOne)) [*4])
    else $error("guarded register write changed a register");
  range_block_a: assert property (
    take && cmdCode == swp_pkg::SWP_ARRAY_OP && blockGuardHit
    |=> !arrayGo [*4])
    else $error("array operation allowed on range-protected sector");
  psl_locked_a: assert property (
    take && !persistentBitLock && $stable(cmdSector[5]) && cmdCode
    inside {swp_pkg::SWP_PROG_PSL, swp_pkg::SWP_ERASE_PSL}
    |-> ##2 programFault)
    else $error("locked persistent bit command did not fail");
  unlock_refuse_a: assert property (
    take && cmdCode == swp_pkg::SWP_UNLOCK && $stable(cmdSector[5])
    && guardMode != swp_pkg::MODE_PASSWORD |-> ##2 programFault)
    else $error("unlock outside password mode did not fail");
  mode_fixed_a: assert property (
    take && guardMode != swp_pkg::MODE_DEFAULT && $stable(cmdSector[5])
    && cmdCode inside {swp_pkg::SWP_PROG_GUARD, swp_pkg::SWP_PROG_PASS,
    swp_pkg::SWP_WRITE_CFGX, swp_pkg::SWP_WRITE_LEARN}
    |-> ##2 (programFault && $stable(guardMode)))
    else $error("configuration change accepted after mode choice");
  mode_illegal_a: assert property (
    take && cmdCode == swp_pkg::SWP_PROG_GUARD
    && cmdData[1:0] == swp_pkg::MODE_ILLEGAL |-> ##2 programFault)
    else $error("illegal mode programming did not fail");
  lock_no_set_a: assert property (
    !$past(persistentBitLock) && $stable(cmdSector[5])
    && $past(cmdSector[5], 2) == cmdSector[5]
    && guardMode != swp_pkg::MODE_PASSWORD
    && $past(guardMode) != swp_pkg::MODE_PASSWORD |-> !persistentBitLock)
    else $error("lock bit set again in persistent mode");
  busy_page_a: assert property (
    $fell(operationBusy) && !programFault && lastCmd inside
    {swp_pkg::SWP_PROG_GUARD, swp_pkg::SWP_PROG_PSL}
    |-> busyLen == 16'(swp_pkg::PAGE_PROG_CYC))
    else $error("program busy time wrong");
  busy_erase_a: assert property (
    $fell(operationBusy) && lastCmd == swp_pkg::SWP_ERASE_PSL
    && !programFault |-> busyLen == 16'(swp_pkg::SECT_ERASE_CYC))
    else $error("erase busy time wrong");
  unlock_gap_a: assert property (
    $fell(operationBusy) && lastCmd == swp_pkg::SWP_UNLOCK && programFault
    && guardMode == swp_pkg::MODE_PASSWORD
    |-> busyLen == 16'(swp_pkg::UNLOCK_GAP_CYC) && !persistentBitLock)
    else $error("failed unlock hold time or lock wrong");
  read_lat_a: assert property (
    take && cmdCode == swp_pkg::SWP_READ_PSL |-> ##RdLat lockReadValid)
    else $error("lock read latency wrong");
endmodule
bind swp_sector_guard swp_sector_guard_checker chk (.*);

//--- swp_host_model.sv
/*
  Host controller model: one command strobe, then busy polling and
  a sample of the fault flag.
  Assumes issue is called just after a rising edge of core_clk.
*/
`timescale 1ns/10ps
module swp_host_model (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Status from the block
  input  wire logic         operationBusy,
  input  wire logic         programFault,
  // Command lines
  output logic              cmdValid,
  output swp_pkg::swp_cmd_e cmdCode,
  output logic [5:0]        cmdSector,
  output logic [63:0]       cmdData
);
  initial begin
    cmdValid  = 1'b0;
    cmdCode   = swp_pkg::SWP_NONE;
    cmdSector = 6'h0;
    cmdData   = 64'h0;
  end
  task automatic issue(input swp_pkg::swp_cmd_e c, input logic [5:0] s,
                       input logic [63:0] d, output logic fault);
    int n;
    n = 0;
    cmdValid  <= resetn;
    cmdCode   <= c;
    cmdSector <= s;
    cmdData   <= d;
    @(posedge core_clk);
    // Sector stays: it selects which die the status outputs show
    cmdValid <= 1'b0;
    cmdCode  <= swp_pkg::SWP_NONE;
    cmdData  <= ~d;
    // A lock read answers three edges after the strobe and the bench
    // captures it one edge later, so wait past that before polling
    repeat (5) @(posedge core_clk);
    while (operationBusy !== 1'b0 && n < 30000) begin
      @(posedge core_clk);
      n++;
    end
    fault = programFault;
  endtask
endmodule

//--- swp_sector_guard_tb.sv
/*
  Testbench for swp_sector_guard: command sequences through the host
  model with expected status values.
  Assumes the checker is bound to the block.
*/
`timescale 1ns/10ps
module swp_sector_guard_tb;
  localparam logic [63:0] secretKey = 64'h5a3c_0f96_c3a5_1e87;
  logic              core_clk = 1'b0;
  logic              resetn = 1'b0;
  logic              writeGuardN = 1'b1;
  logic              blockGuardHit = 1'b0;
  logic              cmdValid;
  swp_pkg::swp_cmd_e cmdCode;
  logic [5:0]        cmdSector;
  logic [63:0]       cmdData;
  logic              operationBusy, programFault, persistentBitLock;
  logic [1:0]        guardMode;
  logic [7:0]        statusOne, configOne;
  logic              lockReadValid, lockReadData, arrayGo;
  logic              flt, rdBit;
  logic [7:0]        goCount = 8'h0;
  int                numErrors = 0;
  int                checksDone = 0;
  swp_sector_guard dut (.*);
  swp_host_model host (.*);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (arrayGo === 1'b1) goCount <= goCount + 8'h1;
    if (lockReadValid === 1'b1) rdBit <= lockReadData;
  end
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk8(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic go(input swp_pkg::swp_cmd_e c, input logic [5:0] s,
                    input logic [63:0] d);
    host.issue(c, s, d, flt);
  endtask
  task automatic printVerdict();
    if (numErrors == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (99000) @(posedge core_clk);
    numErrors++;
    printVerdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chkb("lock", 1'b1, persistentBitLock);
    chk8("mode", 8'h03, {6'h0, guardMode});
    go(swp_pkg::SWP_ARRAY_OP, 6'h03, 64'h0);
    chk8("go", 8'h01, goCount);
    go(swp_pkg::SWP_WRITE_DSL, 6'h03, 64'h0);
    go(swp_pkg::SWP_ARRAY_OP, 6'h03, 64'h0);
    chk8("go", 8'h01, goCount);
    go(swp_pkg::SWP_WRITE_DSL, 6'h03, 64'h1);
    go(swp_pkg::SWP_ARRAY_OP, 6'h03, 64'h0);
    chk8("go", 8'h02, goCount);
    blockGuardHit <= 1'b1;
    go(swp_pkg::SWP_ARRAY_OP, 6'h03, 64'h0);
    chk8("go", 8'h02, goCount);
    blockGuardHit <= 1'b0;
    go(swp_pkg::SWP_PROG_PSL, 6'h03, 64'h0);
    go(swp_pkg::SWP_ARRAY_OP, 6'h03, 64'h0);
    chk8("go", 8'h02, goCount);
    go(swp_pkg::SWP_READ_PSL, 6'h03, 64'h0);
    chkb("psl3", 1'b0, rdBit);
    go(swp_pkg::SWP_READ_PSL, 6'h04, 64'h0);
    chkb("psl4", 1'b1, rdBit);
    go(swp_pkg::SWP_ERASE_PSL, 6'h03, 64'h0);
    go(swp_pkg::SWP_READ_PSL, 6'h03, 64'h0);
    chkb("psl3", 1'b1, rdBit);
    go(swp_pkg::SWP_WRITE_STAT, 6'h03, 64'h80);
    chk8("stat", 8'h80, statusOne);
    writeGuardN <= 1'b0;
    repeat (3) @(posedge core_clk);
    go(swp_pkg::SWP_WRITE_STAT, 6'h03, 64'h84);
    chk8("stat", 8'h80, statusOne);
    go(swp_pkg::SWP_WRITE_CFG1, 6'h03, 64'h04);
    chk8("cfg", 8'h00, configOne);
    writeGuardN <= 1'b1;
    repeat (3) @(posedge core_clk);
    go(swp_pkg::SWP_WRITE_STAT, 6'h03, 64'h00);
    chk8("stat", 8'h00, statusOne);
    go(swp_pkg::SWP_CLEAR_PBL, 6'h03, 64'h0);
    chkb("lock", 1'b0, persistentBitLock);
    go(swp_pkg::SWP_PROG_PSL, 6'h03, 64'h0);
    chkb("fault", 1'b1, flt);
    go(swp_pkg::SWP_ERASE_PSL, 6'h03, 64'h0);
    chkb("fault", 1'b1, flt);
    go(swp_pkg::SWP_UNLOCK, 6'h03, secretKey);
    chkb("lock", 1'b0, persistentBitLock);
    go(swp_pkg::SWP_PROG_GUARD, 6'h03, 64'h0);
    chkb("fault", 1'b1, flt);
    chk8("mode", 8'h03, {6'h0, guardMode});
    go(swp_pkg::SWP_PROG_GUARD, 6'h03, 64'h2);
    chk8("mode", 8'h02, {6'h0, guardMode});
    go(swp_pkg::SWP_PROG_GUARD, 6'h03, 64'h1);
    chkb("fault", 1'b1, flt);
    chk8("mode", 8'h02, {6'h0, guardMode});
    go(swp_pkg::SWP_WRITE_CFGX, 6'h03, 64'h0);
    chkb("fault", 1'b1, flt);
    // Frozen middle bits keep their value, outer bits still follow
    go(swp_pkg::SWP_WRITE_CFG1, 6'h03, 64'hc4);
    chkb("fault", 1'b1, flt);
    chk8("cfg", 8'hc0, configOne);
    go(swp_pkg::SWP_WRITE_LEARN, 6'h03, 64'h0);
    chkb("fault", 1'b1, flt);
    // Second die keeps its own untouched configuration
    go(swp_pkg::SWP_READ_PSL, 6'h28, 64'h0);
    chk8("mode", 8'h03, {6'h0, guardMode});
    chkb("lock", 1'b1, persistentBitLock);
    go(swp_pkg::SWP_PROG_PASS, 6'h28, secretKey);
    chkb("fault", 1'b0, flt);
    go(swp_pkg::SWP_PROG_GUARD, 6'h28, 64'h1);
    chk8("mode", 8'h01, {6'h0, guardMode});
    go(swp_pkg::SWP_PROG_PASS, 6'h28, 64'h0);
    chkb("fault", 1'b1, flt);
    go(swp_pkg::SWP_CLEAR_PBL, 6'h28, 64'h0);
    chkb("lock", 1'b0, persistentBitLock);
    go(swp_pkg::SWP_UNLOCK, 6'h28, ~secretKey);
    chkb("fault", 1'b1, flt);
    chkb("lock", 1'b0, persistentBitLock);
    go(swp_pkg::SWP_UNLOCK, 6'h28, secretKey);
    chkb("fault", 1'b0, flt);
    chkb("lock", 1'b1, persistentBitLock);
    go(swp_pkg::SWP_CLEAR_PBL, 6'h28, 64'h0);
    chkb("lock", 1'b0, persistentBitLock);
    // Mode has no stored copy, so a reset returns to default persistent
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chkb("lock", 1'b1, persistentBitLock);
    chk8("mode", 8'h03, {6'h0, guardMode});
    printVerdict();
  end
endmodule
